// file: hdl/cab_pkg.sv
// shared constants for the cabinet option and ultraviolet control block
package cab_pkg;
    // clock and timing figures
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned HOLD_TIME_S = 3;
    localparam int unsigned SLOW_HALF_MS = 500;
    localparam int unsigned FAST_HALF_MS = 125;
    localparam int unsigned SEC_PER_HOUR = 3600;
    localparam logic [12:0] UV_LIMIT_H = 13'd5000;
    localparam logic [12:0] UV_STEP_H = 13'd450;

    // key positions in the key vector
    localparam int NKEYS = 9;
    localparam int K_MENU = 0;
    localparam int K_HIDDEN = 1;
    localparam int K_BLOWER = 2;
    localparam int K_LIGHT = 3;
    localparam int K_UP = 4;
    localparam int K_DOWN = 5;
    localparam int K_UV = 6;
    localparam int K_OUTLET = 7;
    localparam int K_CANCEL = 8;

    // option count and sync option bit positions
    localparam int NOPT = 7;
    localparam int OPT_FAN = 0;
    localparam int OPT_ACC = 1;
    localparam int OPT_OUTLET = 2;
    localparam int OPT_LIGHT = 3;
    localparam int OPT_DC = 4;

    // register byte offsets
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_UV_TIMER = 8'h04;
    localparam logic [7:0] REG_OPTIONS = 8'h08;
    localparam logic [7:0] REG_UV_HOURS = 8'h0C;

    // reset values
    localparam logic [NOPT-1:0] OPT_RESET = 7'h00;
    localparam logic [15:0] UV_TIMER_RESET = 16'h0000;

    // menu and key sequence states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HID = 3'b001,
        ST_SEQ_BLOWER = 3'b010,
        ST_SEQ_UP = 3'b011,
        ST_MENU_SYNC = 3'b100,
        ST_MENU_AIR = 3'b101
    } menu_state_e;
endpackage

// file: hdl/tick_if.sv
// timebase strobes and blink levels passed from the prescaler to the control logic
`timescale 1ns/1ps
interface tick_if;
    logic sec_tick;
    logic slow_blink;
    logic fast_blink;
    modport src (output sec_tick, output slow_blink, output fast_blink);
    modport dst (input sec_tick, input slow_blink, input fast_blink);
endinterface

// file: hdl/blink_timebase.sv
// prescale counters for the one-second tick and the two blink rates
`timescale 1ns/1ps
module blink_timebase #(
    parameter int unsigned SEC_CYCLES = 25_000_000,
    parameter int unsigned SLOW_HALF = 12_500_000,
    parameter int unsigned FAST_HALF = 3_125_000
) (
    input wire logic pclk,
    input wire logic presetn,
    tick_if.src tb
);
    logic [31:0] sec_cnt_r;
    logic [31:0] slow_cnt_r;
    logic [31:0] fast_cnt_r;

    // one-cycle strobe each second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_cnt_r <= 32'h0;
            tb.sec_tick <= 1'b0;
        end else if (sec_cnt_r == SEC_CYCLES - 1) begin
            sec_cnt_r <= 32'h0;
            tb.sec_tick <= 1'b1;
        end else begin
            sec_cnt_r <= sec_cnt_r + 32'h1;
            tb.sec_tick <= 1'b0;
        end
    end

    // slow blink square wave
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_cnt_r <= 32'h0;
            tb.slow_blink <= 1'b0;
        end else if (slow_cnt_r == SLOW_HALF - 1) begin
            slow_cnt_r <= 32'h0;
            tb.slow_blink <= ~tb.slow_blink;
        end else begin
            slow_cnt_r <= slow_cnt_r + 32'h1;
        end
    end

    // fast blink square wave
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_cnt_r <= 32'h0;
            tb.fast_blink <= 1'b0;
        end else if (fast_cnt_r == FAST_HALF - 1) begin
            fast_cnt_r <= 32'h0;
            tb.fast_blink <= ~tb.fast_blink;
        end else begin
            fast_cnt_r <= fast_cnt_r + 32'h1;
        end
    end
endmodule // blink_timebase

// file: hdl/cabinet_option_and_uv_control.sv
// front-panel option menu, relays, outlets and ultraviolet lamp control with APB status
//
// Summary of operation
// - menu held, then hidden, blower, light keys enter sync menu; blower red blinks fast
// - bar shows one of seven options; ultraviolet key moves left, outlet right
// - up or down toggles option; slow blink means off, fast means on
// - hidden key commits all changes and exits; cancel discards and exits
// - fan relay follows key unless synced, then changes only while blower runs
// - accessory outlet always on, or only while blower runs when synced
// - outlet power follows key; synced it tracks blower, key toggles while running
// - work light follows key; synced it tracks blower, key toggles while running
// - low-voltage output always on, or only while blower runs when synced
// - menu held, then hidden, up, down enter airflow menu with same behaviour
// - fan relay active while blower switched on by key and its LED lit; synced it changes only while blower runs
// - alarm relay active while airflow alarm present
// - lamp starts only with window closed; raising window stops it at once
// - timer set while lamp on turns lamp off at expiry
// - lamp hours accumulate; at limit ultraviolet and red LEDs blink fast
// - menu held plus three ultraviolet presses clears hours and alarm
// - menu and ultraviolet held for hold time show usage on bar
// - after power-up red LED blinks until any key is pressed
`timescale 1ns/1ps
module cabinet_option_and_uv_control #(
    parameter int unsigned SEC_CYCLES = 25_000_000,
    parameter int unsigned SLOW_HALF = 12_500_000,
    parameter int unsigned FAST_HALF = 3_125_000,
    parameter int unsigned HOLD_CYCLES = 75_000_000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [cab_pkg::NKEYS-1:0] keys,
    input wire logic window_closed,
    input wire logic blower_running,
    input wire logic airflow_alarm,
    output logic fan_relay,
    output logic alarm_relay,
    output logic acc_outlet,
    output logic outlet_power,
    output logic work_light,
    output logic dc_out,
    output logic uv_lamp,
    output logic led_blower,
    output logic led_blower_red,
    output logic led_uv,
    output logic led_alarm_red,
    output logic [cab_pkg::NOPT-1:0] led_bar
);
    import cab_pkg::*;

    tick_if tk ();
    menu_state_e state_r;
    logic [NKEYS+2:0] sync1_r, sync2_r, prev_r;
    logic [NKEYS-1:0] kd, kp;
    logic win_ok, run, aflow, run_rise, run_fall, any_press, normal, in_menu;
    logic [NOPT-1:0] sync_opt_r, air_opt_r, shadow_r;
    logic [2:0] sel_r;
    logic blower_on_r, fan_r, outlet_r, light_r, uv_r, pwr_flag_r;
    logic [15:0] uv_timer_r;
    logic [11:0] sec_cnt_r;
    logic [12:0] hours_r;
    logic [1:0] uv_press_r;
    logic [31:0] hold_cnt_r;
    logic show_usage, uv_replace, apb_wr;

    // number of lit bar segments, filling from the left (bar bit 0)
    function automatic logic [NOPT-1:0] bar_fill(input logic [12:0] h);
        logic [12:0] n;
        n = h / UV_STEP_H;
        if (n >= 13'(NOPT)) bar_fill = {NOPT{1'b1}};
        else bar_fill = NOPT'((13'h1 << n) - 13'h1);
    endfunction

    blink_timebase #(
        .SEC_CYCLES(SEC_CYCLES),
        .SLOW_HALF(SLOW_HALF),
        .FAST_HALF(FAST_HALF)
    ) u_timebase (
        .pclk(pclk),
        .presetn(presetn),
        .tb(tk.src)
    );

    // two-stage synchronisers for every pin input, then a third stage for edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r <= '0;
        end else begin
            sync1_r <= {airflow_alarm, blower_running, window_closed, keys};
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    assign kd = sync2_r[NKEYS-1:0];
    assign kp = sync2_r[NKEYS-1:0] & ~prev_r[NKEYS-1:0];
    assign win_ok = sync2_r[NKEYS];
    assign run = sync2_r[NKEYS+1];
    assign aflow = sync2_r[NKEYS+2];
    assign run_rise = run & ~prev_r[NKEYS+1];
    assign run_fall = ~run & prev_r[NKEYS+1];
    assign any_press = |kp;
    assign in_menu = (state_r == ST_MENU_SYNC) || (state_r == ST_MENU_AIR);
    // ordinary key actions are blocked while the menu key is held or a menu is open
    assign normal = (state_r == ST_IDLE) && !kd[K_MENU];

    // key sequence and menu state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (kd[K_MENU] && kp[K_HIDDEN]) state_r <= ST_HID;
                end
                ST_HID: begin
                    if (!kd[K_MENU]) state_r <= ST_IDLE;
                    else if (kp[K_BLOWER]) state_r <= ST_SEQ_BLOWER;
                    else if (kp[K_UP]) state_r <= ST_SEQ_UP;
                    else if (any_press) state_r <= ST_IDLE;
                end
                ST_SEQ_BLOWER: begin
                    if (!kd[K_MENU]) state_r <= ST_IDLE;
                    else if (kp[K_LIGHT]) state_r <= ST_MENU_SYNC;
                    else if (any_press) state_r <= ST_IDLE;
                end
                ST_SEQ_UP: begin
                    if (!kd[K_MENU]) state_r <= ST_IDLE;
                    else if (kp[K_DOWN]) state_r <= ST_MENU_AIR;
                    else if (any_press) state_r <= ST_IDLE;
                end
                ST_MENU_SYNC, ST_MENU_AIR: begin
                    if (kp[K_HIDDEN] || kp[K_CANCEL]) state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // selection cursor and shadow copy of the open menu's options
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_r <= 3'h0;
            shadow_r <= OPT_RESET;
        end else if (state_r == ST_SEQ_BLOWER && kd[K_MENU] && kp[K_LIGHT]) begin
            sel_r <= 3'h0;
            shadow_r <= sync_opt_r;
        end else if (state_r == ST_SEQ_UP && kd[K_MENU] && kp[K_DOWN]) begin
            sel_r <= 3'h0;
            shadow_r <= air_opt_r;
        end else if (in_menu) begin
            // cursor stops at the ends rather than wrapping
            if (kp[K_UV] && sel_r != 3'h0) sel_r <= sel_r - 3'h1;
            else if (kp[K_OUTLET] && sel_r != 3'(NOPT - 1)) sel_r <= sel_r + 3'h1;
            if (kp[K_UP] || kp[K_DOWN]) shadow_r[sel_r] <= ~shadow_r[sel_r];
        end
    end

    // active option sets change only on accept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_opt_r <= OPT_RESET;
            air_opt_r <= OPT_RESET;
        end else if (kp[K_HIDDEN] && !kp[K_CANCEL]) begin
            if (state_r == ST_MENU_SYNC) sync_opt_r <= shadow_r;
            if (state_r == ST_MENU_AIR) air_opt_r <= shadow_r;
        end
    end

    // blower switched on by key, and fan relay with optional running sync
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blower_on_r <= 1'b0;
            fan_r <= 1'b0;
        end else begin
            if (normal && kp[K_BLOWER]) blower_on_r <= ~blower_on_r;
            if (!sync_opt_r[OPT_FAN]) fan_r <= blower_on_r;
            else if (run) fan_r <= blower_on_r;
        end
    end

    // outlet power and work light: key toggle, or blower tracking when synced
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            outlet_r <= 1'b0;
            light_r <= 1'b0;
        end else begin
            if (!sync_opt_r[OPT_OUTLET]) begin
                if (normal && kp[K_OUTLET]) outlet_r <= ~outlet_r;
            end else if (run_rise) outlet_r <= 1'b1;
            else if (run_fall) outlet_r <= 1'b0;
            else if (run && normal && kp[K_OUTLET]) outlet_r <= ~outlet_r;
            if (!sync_opt_r[OPT_LIGHT]) begin
                if (normal && kp[K_LIGHT]) light_r <= ~light_r;
            end else if (run_rise) light_r <= 1'b1;
            else if (run_fall) light_r <= 1'b0;
            else if (run && normal && kp[K_LIGHT]) light_r <= ~light_r;
        end
    end

    assign apb_wr = psel && penable && pwrite && (paddr == REG_UV_TIMER);

    // timer in seconds; a bus write wins over the countdown in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uv_timer_r <= UV_TIMER_RESET;
        end else if (apb_wr) begin
            uv_timer_r <= pwdata[15:0];
        end else if (uv_r && tk.sec_tick && uv_timer_r != 16'h0) begin
            uv_timer_r <= uv_timer_r - 16'h1;
        end
    end

    // lamp on/off: window interlock overrides everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uv_r <= 1'b0;
        end else if (!win_ok) begin
            uv_r <= 1'b0;
        end else if (uv_r && tk.sec_tick && uv_timer_r == 16'h1 && !apb_wr) begin
            uv_r <= 1'b0;
        end else if (normal && kp[K_UV]) begin
            uv_r <= ~uv_r;
        end
    end

    // lamp hour meter; saturates rather than wrapping past the counter width
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_cnt_r <= 12'h0;
            hours_r <= 13'h0;
        end else if (state_r == ST_IDLE && kd[K_MENU] && kp[K_UV] && uv_press_r == 2'h2) begin
            sec_cnt_r <= 12'h0;
            hours_r <= 13'h0;
        end else if (uv_r && tk.sec_tick) begin
            if (sec_cnt_r == 12'(SEC_PER_HOUR - 1)) begin
                sec_cnt_r <= 12'h0;
                if (hours_r != 13'h1FFF) hours_r <= hours_r + 13'h1;
            end else begin
                sec_cnt_r <= sec_cnt_r + 12'h1;
            end
        end
    end

    // ultraviolet presses counted while the menu key stays held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uv_press_r <= 2'h0;
        end else if (!kd[K_MENU] || state_r != ST_IDLE) begin
            uv_press_r <= 2'h0;
        end else if (kp[K_UV]) begin
            uv_press_r <= (uv_press_r == 2'h2) ? 2'h0 : uv_press_r + 2'h1;
        end
    end

    // hold timer for the usage display
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt_r <= 32'h0;
        end else if (!(kd[K_MENU] && kd[K_UV]) || state_r != ST_IDLE) begin
            hold_cnt_r <= 32'h0;
        end else if (hold_cnt_r != HOLD_CYCLES) begin
            hold_cnt_r <= hold_cnt_r + 32'h1;
        end
    end

    assign show_usage = (hold_cnt_r == HOLD_CYCLES);
    assign uv_replace = (hours_r >= UV_LIMIT_H);

    // power interruption flag set by reset, cleared by any key
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pwr_flag_r <= 1'b1;
        else if (any_press) pwr_flag_r <= 1'b0;
    end

    // registered outputs to relays, outlets and LEDs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fan_relay <= 1'b0;
            alarm_relay <= 1'b0;
            acc_outlet <= 1'b0;
            outlet_power <= 1'b0;
            work_light <= 1'b0;
            dc_out <= 1'b0;
            uv_lamp <= 1'b0;
            led_blower <= 1'b0;
            led_blower_red <= 1'b0;
            led_uv <= 1'b0;
            led_alarm_red <= 1'b0;
            led_bar <= '0;
        end else begin
            fan_relay <= fan_r;
            alarm_relay <= aflow;
            acc_outlet <= !sync_opt_r[OPT_ACC] || run;
            outlet_power <= outlet_r;
            work_light <= light_r;
            dc_out <= !sync_opt_r[OPT_DC] || run;
            uv_lamp <= uv_r && win_ok;
            led_blower <= blower_on_r;
            led_blower_red <= in_menu && tk.fast_blink;
            led_uv <= uv_replace ? tk.fast_blink : uv_r;
            led_alarm_red <= (uv_replace && tk.fast_blink) || aflow
                || (pwr_flag_r && tk.slow_blink);
            if (in_menu) begin
                led_bar <= NOPT'(7'h01 << sel_r)
                    & {NOPT{shadow_r[sel_r] ? tk.fast_blink : tk.slow_blink}};
            end else if (show_usage) begin
                led_bar <= bar_fill(hours_r);
            end else begin
                led_bar <= '0;
            end
        end
    end

    // APB slave: zero wait states, read data captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(paddr == REG_STATUS || paddr == REG_UV_TIMER
        || paddr == REG_OPTIONS || paddr == REG_UV_HOURS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            unique case (paddr)
                REG_STATUS: prdata <= {23'h0, light_r, outlet_r, in_menu, pwr_flag_r,
                    uv_replace, aflow, fan_r, blower_on_r, uv_r};
                REG_UV_TIMER: prdata <= {16'h0, uv_timer_r};
                REG_OPTIONS: prdata <= {17'h0, air_opt_r, 1'b0, sync_opt_r};
                REG_UV_HOURS: prdata <= {19'h0, hours_r};
                default: prdata <= 32'h0;
            endcase
        end
    end
endmodule // cabinet_option_and_uv_control

// file: testbench/cab_asserts.sv
// port-level assertion checker for the cabinet control block
`timescale 1ns/1ps
module cab_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pslverr,
    input wire logic window_closed,
    input wire logic blower_running,
    input wire logic airflow_alarm,
    input wire logic fan_relay,
    input wire logic alarm_relay,
    input wire logic acc_outlet,
    input wire logic dc_out,
    input wire logic uv_lamp,
    input wire logic led_blower,
    input wire logic led_blower_red
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic mapped;
    // decode shared by both error checks
    assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C};
    // pins pass two sync stages and a register, so six samples cover the latency
    sequence s_alarm_held;
        airflow_alarm [*6];
    endsequence
    sequence s_blower_held;
        blower_running [*6];
    endsequence
    a_alarm_relay_on: assert property (s_alarm_held |-> alarm_relay)
        else $error("alarm relay idle while airflow alarm held");
    a_window_kills_uv: assert property ($fell(window_closed) |-> ##[1:5] !uv_lamp)
        else $error("lamp still lit after window raised");
    a_uv_needs_closed: assert property ($rose(uv_lamp) |->
        window_closed && $past(window_closed, 3))
        else $error("lamp lit with window open");
    a_acc_when_running: assert property (s_blower_held |-> acc_outlet)
        else $error("accessory outlet off with blower running");
    a_dc_when_running: assert property (s_blower_held |-> dc_out)
        else $error("dc output off with blower running");
    a_fan_with_led: assert property ($rose(fan_relay) |-> ##[0:1] led_blower)
        else $error("fan relay on without blower led");
    a_menu_blink_width: assert property ($rose(led_blower_red) |-> ##[1:8] !led_blower_red)
        else $error("menu led steady instead of blinking");
    a_unmapped_error: assert property (psel && penable && !mapped |-> pslverr)
        else $error("no error on unmapped access");
    a_mapped_no_error: assert property (psel && penable && mapped |-> !pslverr)
        else $error("error on mapped access");
    a_idle_no_error: assert property (!(psel && penable) |-> !pslverr)
        else $error("error outside access phase");
endmodule // cab_asserts

bind cabinet_option_and_uv_control cab_asserts chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pslverr(pslverr), .window_closed(window_closed), .blower_running(blower_running),
    .airflow_alarm(airflow_alarm), .fan_relay(fan_relay), .alarm_relay(alarm_relay),
    .acc_outlet(acc_outlet), .dc_out(dc_out), .uv_lamp(uv_lamp), .led_blower(led_blower),
    .led_blower_red(led_blower_red)
);

// file: testbench/panel_model.sv
// operator panel model: keypad, window switch and blower and airflow sense lines
`timescale 1ns/1ps
module panel_model (
    input wire logic pclk,
    output logic [cab_pkg::NKEYS-1:0] keys,
    output logic window_closed,
    output logic blower_running,
    output logic airflow_alarm
);
    import cab_pkg::*;
    // window closed, blower stopped, no alarm at power-up
    initial begin
        keys = '0;
        window_closed = 1'b1;
        blower_running = 1'b0;
        airflow_alarm = 1'b0;
    end
    // key held then released seven cycles each, so the sync stages never merge presses
    task automatic press(input int k);
        hold(k, 1'b1);
        hold(k, 1'b0);
    endtask
    task automatic hold(input int k, input logic v);
        @(posedge pclk);
        keys[k] <= v;
        repeat (6) @(posedge pclk);
    endtask
    // switch lines are levels; settle time lets outputs follow
    task automatic set_lines(input logic w, input logic b, input logic a);
        @(posedge pclk);
        window_closed <= w;
        blower_running <= b;
        airflow_alarm <= a;
        repeat (8) @(posedge pclk);
    endtask
endmodule // panel_model

// file: testbench/tb_top.sv
// self-checking bench: apb register access and operator panel scenarios
`timescale 1ns/1ps
module tb_top;
    import cab_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, window_closed, blower_running, airflow_alarm;
    logic fan_relay, alarm_relay, acc_outlet, outlet_power, work_light, dc_out, uv_lamp;
    logic led_blower, led_blower_red, led_uv, led_alarm_red;
    logic [NKEYS-1:0] keys;
    logic [NOPT-1:0] led_bar;
    int mismatches = 0;
    int tests_run = 0;
    int n;
    // 25 MHz clock
    always #20 pclk = ~pclk;
    // short prescales keep the hour count reachable in simulation
    cabinet_option_and_uv_control #(.SEC_CYCLES(2), .SLOW_HALF(8), .FAST_HALF(2),
        .HOLD_CYCLES(50)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .keys(keys), .window_closed(window_closed), .blower_running(blower_running),
        .airflow_alarm(airflow_alarm), .fan_relay(fan_relay), .alarm_relay(alarm_relay),
        .acc_outlet(acc_outlet), .outlet_power(outlet_power), .work_light(work_light),
        .dc_out(dc_out), .uv_lamp(uv_lamp), .led_blower(led_blower),
        .led_blower_red(led_blower_red), .led_uv(led_uv), .led_alarm_red(led_alarm_red),
        .led_bar(led_bar));
    panel_model panel_u (.pclk(pclk), .keys(keys), .window_closed(window_closed),
        .blower_running(blower_running), .airflow_alarm(airflow_alarm));
    task automatic conclude();
        if (mismatches == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            conclude();
        end
        rd = prdata;
        check(pslverr, err);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 1'b0);
        check(rd, exp);
    endtask
    task automatic menu_open(input int k2, input int k3);
        panel_u.hold(K_MENU, 1'b1);
        panel_u.press(K_HIDDEN);
        panel_u.press(k2);
        panel_u.press(k3);
        panel_u.hold(K_MENU, 1'b0);
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // map after reset, read-only write and unmapped access
        rd_chk(REG_STATUS, 32'h20);
        apb(1'b1, REG_STATUS, 32'hFFFF_FFFF, 1'b0);
        rd_chk(REG_STATUS, 32'h20);
        apb(1'b1, 8'h10, 32'hFFFF_FFFF, 1'b1);
        apb(1'b0, 8'h10, 32'h0, 1'b1);
        check(rd, 32'h0);
        panel_u.press(K_CANCEL);
        rd_chk(REG_STATUS, 32'h0);
        check(led_alarm_red, 1'b0);
        check(acc_outlet, 1'b1);
        check(dc_out, 1'b1);
        // blower pending: relay follows the key
        panel_u.press(K_BLOWER);
        check(fan_relay, 1'b1);
        check(led_blower, 1'b1);
        panel_u.press(K_OUTLET);
        panel_u.press(K_LIGHT);
        check(outlet_power, 1'b1);
        check(work_light, 1'b1);
        rd_chk(REG_STATUS, 32'h186);
        panel_u.press(K_OUTLET);
        panel_u.press(K_LIGHT);
        check(outlet_power | work_light, 1'b0);
        panel_u.set_lines(1'b1, 1'b0, 1'b1);
        check(alarm_relay, 1'b1);
        rd_chk(REG_STATUS, 32'h0E);
        panel_u.set_lines(1'b1, 1'b0, 1'b0);
        check(alarm_relay, 1'b0);
        // same edits twice: first discarded, then accepted
        for (int p = 0; p < 2; p++) begin
            menu_open(K_BLOWER, K_LIGHT);
            rd_chk(REG_STATUS, 32'h46);
            for (n = 0; n < 8 && led_blower_red !== 1'b1; n++) @(posedge pclk);
            check(led_blower_red, 1'b1);
            check(led_bar[6:1], 6'h00);
            panel_u.press(K_UV);
            for (int i = 0; i < 5; i++) begin
                panel_u.press(K_UP);
                panel_u.press(K_OUTLET);
            end
            panel_u.press(K_DOWN);
            panel_u.press(K_DOWN);
            check(led_bar[4:0], 5'h00);
            rd_chk(REG_OPTIONS, 32'h0);
            panel_u.press(p ? K_HIDDEN : K_CANCEL);
        end
        rd_chk(REG_OPTIONS, 32'h1F);
        check(acc_outlet | dc_out, 1'b0);
        panel_u.press(K_BLOWER);
        check(fan_relay, 1'b1);
        panel_u.set_lines(1'b1, 1'b1, 1'b0);
        check(fan_relay, 1'b0);
        check(acc_outlet & dc_out, 1'b1);
        check(outlet_power & work_light, 1'b1);
        panel_u.press(K_OUTLET);
        check(outlet_power, 1'b0);
        panel_u.set_lines(1'b1, 1'b0, 1'b0);
        check(work_light, 1'b0);
        panel_u.press(K_OUTLET);
        check(outlet_power, 1'b0);
        menu_open(K_UP, K_DOWN);
        rd_chk(REG_STATUS, 32'h40);
        panel_u.press(K_UP);
        panel_u.press(K_HIDDEN);
        rd_chk(REG_OPTIONS, 32'h011F);
        // window interlock: open refuses, raising stops, closing does not relight
        panel_u.set_lines(1'b0, 1'b0, 1'b0);
        panel_u.press(K_UV);
        check(uv_lamp, 1'b0);
        panel_u.set_lines(1'b1, 1'b0, 1'b0);
        panel_u.press(K_UV);
        check(uv_lamp, 1'b1);
        check(led_uv, 1'b1);
        panel_u.set_lines(1'b0, 1'b0, 1'b0);
        check(uv_lamp, 1'b0);
        panel_u.set_lines(1'b1, 1'b0, 1'b0);
        check(uv_lamp, 1'b0);
        // three seconds at two cycles each, plus sync and register latency
        panel_u.press(K_UV);
        apb(1'b1, REG_UV_TIMER, 32'h3, 1'b0);
        for (n = 0; n < 40 && uv_lamp !== 1'b0; n++) @(posedge pclk);
        check(n >= 4 && n <= 12, 1'b1);
        rd_chk(REG_UV_TIMER, 32'h0);
        // one hour of lamp time, then cleared by the key sequence
        panel_u.press(K_UV);
        repeat (7300) @(posedge pclk);
        rd_chk(REG_UV_HOURS, 32'h1);
        panel_u.press(K_UV);
        panel_u.hold(K_MENU, 1'b1);
        repeat (3) panel_u.press(K_UV);
        panel_u.hold(K_MENU, 1'b0);
        rd_chk(REG_UV_HOURS, 32'h0);
        check(uv_lamp, 1'b0);
        conclude();
    end
endmodule // tb_top
